/* File: hw/pacg_pin_cell.sv */
// output driver of one shared pin: gpio or peripheral ownership
`timescale 1ns/1ps

module pacg_pin_cell (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic alt_own,
  input wire logic alt_out,
  input wire logic alt_oe,
  output logic pad_out,
  output logic pad_oe
);

  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;

  // ==========================================================================
  // a peripheral that owns the pin sets its direction; the gpio direction
  // bit is not consulted then, and is not altered either
  always_comb begin
    out_next = out_reg;
    oe_next = oe_reg;
    if (clk_en) begin
      if (alt_own) begin
        out_next = alt_out;
        oe_next = alt_oe;
      end else begin
        out_next = gpio_out;
        oe_next = gpio_dir;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pad_out = out_reg;
  assign pad_oe = oe_reg;

endmodule

/* File: hw/pacg_pkg.sv */
// shared constants, types and decode function of the port a / port c pin block
package pacg_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PA_W = 6;
  localparam int PC_W = 2;
  localparam int SPI_W = 4;

  // ==========================================================================
  // register offsets (byte addresses on the plain register port)
  localparam logic [ADDR_W-1:0] OFS_PORT_A_DATA = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_RSVD_AFTER_A = 9'h001;
  localparam logic [ADDR_W-1:0] OFS_PORT_A_DIR = 9'h002;
  localparam logic [ADDR_W-1:0] OFS_RSVD_AFTER_DIR_A = 9'h003;
  localparam logic [ADDR_W-1:0] OFS_PORT_C_DATA = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_PORT_C_DIR = 9'h006;

  // ==========================================================================
  // field layout and reset values
  localparam logic [DATA_W-1:0] PA_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] PC_MASK = 8'h03;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [PA_W-1:0] PA_RESET = 6'h00;
  localparam logic [PC_W-1:0] PC_RESET = 2'h0;

  // port a pin positions of the spi signals
  localparam int PIN_SPI_SS = 3;
  localparam int PIN_SPI_SCK = 2;
  localparam int PIN_SPI_MOSI = 1;
  localparam int PIN_SPI_MISO = 0;

  // port c pin positions of the die link signals
  localparam int PIN_DL_INT = 1;
  localparam int PIN_DL_CLK = 0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PA_DATA,
    SEL_PA_DIR,
    SEL_PC_DATA,
    SEL_PC_DIR
  } pacg_sel_t;

  // drive request of the spi module for port a pins 3..0
  typedef struct packed {
    logic [SPI_W-1:0] out;
    logic [SPI_W-1:0] oe;
  } pacg_spi_drive_t;

  // ==========================================================================
  // address decode; reserved and unknown addresses give SEL_NONE
  function automatic pacg_sel_t decode(input logic [ADDR_W-1:0] addr);
    pacg_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      OFS_PORT_A_DATA: sel = SEL_PA_DATA;
      OFS_PORT_A_DIR: sel = SEL_PA_DIR;
      OFS_PORT_C_DATA: sel = SEL_PC_DATA;
      OFS_PORT_C_DIR: sel = SEL_PC_DIR;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

/* File: hw/pacg_sync.sv */
// two-flop synchroniser for one pin input
`timescale 1ns/1ps

module pacg_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic d,
  output logic q
);

  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  // ==========================================================================
  // next state: the first stage feeds only the second stage
  always_comb begin
    meta_next = meta_reg;
    q_next = q_reg;
    if (clk_en) begin
      meta_next = d;
      q_next = meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

/* File: hw/pacg_top.sv */
// port a / port c gpio registers and pin sharing with spi and die link
//
// Overview of operation
// - read of a data register: latched bit if direction is 1, else synced pin
// - port a data bits 5..0 read/write anytime, bits 7..6 read zero, reset zero
// - port a pins 3..0 carry spi ss, sck, mosi, miso while spi uses them
// - spi sets port a pin direction while owning; direction bits stay unchanged
// - gpio port a: direction 1 drives the pin, 0 leaves it high-impedance input
// - reserved register after port a data reads zero, writes ignored
// - port c pin 1 is die link interrupt in, pin 0 its clock out when enabled
// - port c data bits 1..0 read/write anytime, bits 7..2 read zero, reset zero
// - die link sets port c direction when enabled; gpio direction 1 out, 0 in
`timescale 1ns/1ps

module pacg_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [pacg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pacg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pacg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pacg_pkg::PA_W-1:0] pa_pin_in,
  output logic [pacg_pkg::PA_W-1:0] pa_pin_out,
  output logic [pacg_pkg::PA_W-1:0] pa_pin_oe,
  input wire logic [pacg_pkg::PC_W-1:0] pc_pin_in,
  output logic [pacg_pkg::PC_W-1:0] pc_pin_out,
  output logic [pacg_pkg::PC_W-1:0] pc_pin_oe,
  input wire logic [pacg_pkg::SPI_W-1:0] spi_own,
  input wire pacg_pkg::pacg_spi_drive_t spi_drive,
  output logic [pacg_pkg::SPI_W-1:0] spi_pin_sync,
  input wire logic die_link_enable,
  input wire logic die_link_clock_out,
  output logic die_link_interrupt_in
);

  // ==========================================================================
  // register state
  logic [pacg_pkg::PA_W-1:0] pa_data_reg;
  logic [pacg_pkg::PA_W-1:0] pa_data_next;
  logic [pacg_pkg::PA_W-1:0] pa_dir_reg;
  logic [pacg_pkg::PA_W-1:0] pa_dir_next;
  logic [pacg_pkg::PC_W-1:0] pc_data_reg;
  logic [pacg_pkg::PC_W-1:0] pc_data_next;
  logic [pacg_pkg::PC_W-1:0] pc_dir_reg;
  logic [pacg_pkg::PC_W-1:0] pc_dir_next;
  logic [pacg_pkg::DATA_W-1:0] rdata_reg;
  logic [pacg_pkg::DATA_W-1:0] rdata_next;
  logic [pacg_pkg::SPI_W-1:0] spi_in_reg;
  logic [pacg_pkg::SPI_W-1:0] spi_in_next;
  logic dl_int_reg;
  logic dl_int_next;

  // synchronised pin levels
  logic [pacg_pkg::PA_W-1:0] pa_sync;
  logic [pacg_pkg::PC_W-1:0] pc_sync;

  // peripheral ownership and drive per pin
  logic [pacg_pkg::PA_W-1:0] pa_alt_own;
  logic [pacg_pkg::PA_W-1:0] pa_alt_out;
  logic [pacg_pkg::PA_W-1:0] pa_alt_oe;
  logic [pacg_pkg::PC_W-1:0] pc_alt_own;
  logic [pacg_pkg::PC_W-1:0] pc_alt_out;
  logic [pacg_pkg::PC_W-1:0] pc_alt_oe;

  pacg_pkg::pacg_sel_t wr_sel;
  pacg_pkg::pacg_sel_t rd_sel;

  // read-back words of the four mapped registers, upper bits already zero
  logic [pacg_pkg::DATA_W-1:0] pa_data_word;
  logic [pacg_pkg::DATA_W-1:0] pa_dir_word;
  logic [pacg_pkg::DATA_W-1:0] pc_data_word;
  logic [pacg_pkg::DATA_W-1:0] pc_dir_word;

  // ==========================================================================
  // read-back of a data register, per pin: output pins show the latch,
  // input pins show the synchronised level
  function automatic logic [pacg_pkg::DATA_W-1:0] readback(
    input logic [pacg_pkg::DATA_W-1:0] latch,
    input logic [pacg_pkg::DATA_W-1:0] dir,
    input logic [pacg_pkg::DATA_W-1:0] pin,
    input logic [pacg_pkg::DATA_W-1:0] mask
  );
    logic [pacg_pkg::DATA_W-1:0] v;
    v = (latch & dir) | (pin & ~dir);
    return v & mask;
  endfunction

  // zero-extend a narrow field to the data width
  function automatic logic [pacg_pkg::DATA_W-1:0] widen_a(
    input logic [pacg_pkg::PA_W-1:0] f
  );
    return {{(pacg_pkg::DATA_W-pacg_pkg::PA_W){1'b0}}, f};
  endfunction

  function automatic logic [pacg_pkg::DATA_W-1:0] widen_c(
    input logic [pacg_pkg::PC_W-1:0] f
  );
    return {{(pacg_pkg::DATA_W-pacg_pkg::PC_W){1'b0}}, f};
  endfunction

  // ==========================================================================
  // input synchronisers, shared by read-back and peripherals
  for (genvar i = 0; i < pacg_pkg::PA_W; i++) begin : g_pa_sync
    pacg_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .d(pa_pin_in[i]),
      .q(pa_sync[i])
    );
  end

  for (genvar i = 0; i < pacg_pkg::PC_W; i++) begin : g_pc_sync
    pacg_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .d(pc_pin_in[i]),
      .q(pc_sync[i])
    );
  end

  // ==========================================================================
  // pin ownership: spi on port a 3..0, die link on port c 1..0
  always_comb begin
    pa_alt_own = '0;
    pa_alt_out = '0;
    pa_alt_oe = '0;
    pa_alt_own[pacg_pkg::SPI_W-1:0] = spi_own;
    pa_alt_out[pacg_pkg::SPI_W-1:0] = spi_drive.out;
    pa_alt_oe[pacg_pkg::SPI_W-1:0] = spi_drive.oe;
  end

  // the die link takes both port c pins at once; there is no per-pin split
  always_comb begin
    pc_alt_own = {pacg_pkg::PC_W{die_link_enable}};
    pc_alt_out = '0;
    pc_alt_oe = '0;
    // clock pin is always driven by the link; interrupt pin only listens
    pc_alt_out[pacg_pkg::PIN_DL_CLK] = die_link_clock_out;
    pc_alt_oe[pacg_pkg::PIN_DL_CLK] = 1'b1;
    pc_alt_oe[pacg_pkg::PIN_DL_INT] = 1'b0;
  end

  // ==========================================================================
  // pin drivers; outputs are registered inside each cell
  for (genvar i = 0; i < pacg_pkg::PA_W; i++) begin : g_pa_cell
    pacg_pin_cell u_cell (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .gpio_out(pa_data_reg[i]),
      .gpio_dir(pa_dir_reg[i]),
      .alt_own(pa_alt_own[i]),
      .alt_out(pa_alt_out[i]),
      .alt_oe(pa_alt_oe[i]),
      .pad_out(pa_pin_out[i]),
      .pad_oe(pa_pin_oe[i])
    );
  end

  for (genvar i = 0; i < pacg_pkg::PC_W; i++) begin : g_pc_cell
    pacg_pin_cell u_cell (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .gpio_out(pc_data_reg[i]),
      .gpio_dir(pc_dir_reg[i]),
      .alt_own(pc_alt_own[i]),
      .alt_out(pc_alt_out[i]),
      .alt_oe(pc_alt_oe[i]),
      .pad_out(pc_pin_out[i]),
      .pad_oe(pc_pin_oe[i])
    );
  end

  // ==========================================================================
  // register writes; peripheral ownership never touches the direction bits,
  // so software sees its own setting back once the peripheral lets go
  always_comb begin
    wr_sel = pacg_pkg::decode(reg_addr);
    pa_data_next = pa_data_reg;
    pa_dir_next = pa_dir_reg;
    pc_data_next = pc_data_reg;
    pc_dir_next = pc_dir_reg;
    if (clk_en && reg_wr) begin
      case (wr_sel)
        pacg_pkg::SEL_PA_DATA: begin
          pa_data_next = reg_wdata[pacg_pkg::PA_W-1:0];
        end
        pacg_pkg::SEL_PA_DIR: begin
          pa_dir_next = reg_wdata[pacg_pkg::PA_W-1:0];
        end
        pacg_pkg::SEL_PC_DATA: begin
          pc_data_next = reg_wdata[pacg_pkg::PC_W-1:0];
        end
        pacg_pkg::SEL_PC_DIR: begin
          pc_dir_next = reg_wdata[pacg_pkg::PC_W-1:0];
        end
        default: begin
          // reserved and unmapped addresses: write dropped, no side effect
        end
      endcase
    end
  end

  // ==========================================================================
  // read-back words; the synchronised level is used, never the raw pin, so a
  // pin moving near the edge cannot put a metastable bit on the bus
  always_comb begin
    pa_data_word = readback(widen_a(pa_data_reg), widen_a(pa_dir_reg),
                            widen_a(pa_sync), pacg_pkg::PA_MASK);
    pa_dir_word = widen_a(pa_dir_reg) & pacg_pkg::PA_MASK;
    pc_data_word = readback(widen_c(pc_data_reg), widen_c(pc_dir_reg),
                            widen_c(pc_sync), pacg_pkg::PC_MASK);
    pc_dir_word = widen_c(pc_dir_reg) & pacg_pkg::PC_MASK;
  end

  // ==========================================================================
  // register reads: data valid from the edge after the read strobe until the next enabled edge
  always_comb begin
    rd_sel = pacg_pkg::decode(reg_addr);
    rdata_next = rdata_reg;
    if (clk_en) begin
      rdata_next = pacg_pkg::READ_ZERO;
      if (reg_rd) begin
        case (rd_sel)
          pacg_pkg::SEL_PA_DATA: begin
            rdata_next = pa_data_word;
          end
          pacg_pkg::SEL_PA_DIR: begin
            rdata_next = pa_dir_word;
          end
          pacg_pkg::SEL_PC_DATA: begin
            rdata_next = pc_data_word;
          end
          pacg_pkg::SEL_PC_DIR: begin
            rdata_next = pc_dir_word;
          end
          default: begin
            rdata_next = pacg_pkg::READ_ZERO;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // synchronised levels handed to the peripherals, registered so that the
  // outputs stay glitch free; costs one cycle of latency
  // unowned pins read zero, so a gpio toggle cannot reach a peripheral input
  always_comb begin
    spi_in_next = spi_in_reg;
    dl_int_next = dl_int_reg;
    if (clk_en) begin
      spi_in_next = pa_sync[pacg_pkg::SPI_W-1:0] & spi_own;
      dl_int_next = die_link_enable & pc_sync[pacg_pkg::PIN_DL_INT];
    end
  end

  // ==========================================================================
  // state registers, one block per group of state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pa_data_reg <= pacg_pkg::PA_RESET;
      pa_dir_reg <= pacg_pkg::PA_RESET;
      pc_data_reg <= pacg_pkg::PC_RESET;
      pc_dir_reg <= pacg_pkg::PC_RESET;
    end else begin
      pa_data_reg <= pa_data_next;
      pa_dir_reg <= pa_dir_next;
      pc_data_reg <= pc_data_next;
      pc_dir_reg <= pc_dir_next;
    end
  end

  // read data falls back to zero at the next enabled edge, so reset and idle agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= pacg_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_in_reg <= '0;
      dl_int_reg <= 1'b0;
    end else begin
      spi_in_reg <= spi_in_next;
      dl_int_reg <= dl_int_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign spi_pin_sync = spi_in_reg;
  assign die_link_interrupt_in = dl_int_reg;

endmodule

/* File: test/pacg_periph_model.sv */
// behavioural spi and die link peer that takes over shared pins on request
`timescale 1ns/1ps

module pacg_periph_model (
  input wire logic ref_clk,
  input wire logic [pacg_pkg::SPI_W-1:0] own_req,
  input wire logic link_req,
  output logic [pacg_pkg::SPI_W-1:0] spi_own,
  output pacg_pkg::pacg_spi_drive_t spi_drive,
  output logic die_link_enable,
  output logic die_link_clock_out
);
  initial begin
    spi_own = 4'h0;
    spi_drive = 8'h00;
    die_link_enable = 1'b0;
    die_link_clock_out = 1'b0;
  end

  always @(posedge ref_clk) begin
    spi_own <= own_req;
    // unowned pins get noise so any leak past the ownership mask shows
    spi_drive.out <= 4'($urandom);
    spi_drive.oe <= (own_req & 4'he) | (~own_req & 4'($urandom));
    die_link_enable <= link_req;
    // link clock stands low while the link is off
    die_link_clock_out <= link_req & ~die_link_clock_out;
  end
endmodule

/* File: test/pacg_top_monitor.sv */
// assertion checker watching the ports of the port a / port c pin block
`timescale 1ns/1ps

module pacg_mon (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [pacg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [pacg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pacg_pkg::PA_W-1:0] pa_pin_in,
  input wire logic [pacg_pkg::PA_W-1:0] pa_pin_out,
  input wire logic [pacg_pkg::PA_W-1:0] pa_pin_oe,
  input wire logic [pacg_pkg::PC_W-1:0] pc_pin_in,
  input wire logic [pacg_pkg::PC_W-1:0] pc_pin_out,
  input wire logic [pacg_pkg::PC_W-1:0] pc_pin_oe,
  input wire logic [pacg_pkg::SPI_W-1:0] spi_own,
  input wire pacg_pkg::pacg_spi_drive_t spi_drive,
  input wire logic [pacg_pkg::SPI_W-1:0] spi_pin_sync,
  input wire logic die_link_enable,
  input wire logic die_link_clock_out,
  input wire logic die_link_interrupt_in
);
  // ==========================================================================
  // run length of clocked edges out of reset; frozen edges restart it
  logic [1:0] run_reg;
  logic [1:0] run_next;

  always_comb begin
    run_next = 2'h0;
    if (rst_n && clk_en) begin
      run_next = (run_reg == 2'h3) ? 2'h3 : run_reg + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    run_reg <= run_next;
  end

  // ==========================================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_spi_oe_take: assert property (
    run_reg != 2'h0 |-> ((pa_pin_oe[3:0] ^ $past(spi_drive.oe)) & $past(spi_own)) == 4'h0)
    else $error("spi owned pin enable mismatch");
  chk_spi_out_take: assert property (
    run_reg != 2'h0 |-> ((pa_pin_out[3:0] ^ $past(spi_drive.out)) & $past(spi_own)) == 4'h0)
    else $error("spi owned pin value mismatch");
  chk_link_clk_drive: assert property (
    run_reg != 2'h0 && $past(die_link_enable) |->
      pc_pin_oe[0] && pc_pin_out[0] == $past(die_link_clock_out))
    else $error("link clock pin not driven");
  chk_link_int_input: assert property (
    run_reg != 2'h0 && $past(die_link_enable) |-> !pc_pin_oe[1])
    else $error("link interrupt pin driven");
  chk_spi_sync_lat: assert property (
    run_reg == 2'h3 |-> spi_pin_sync == ($past(spi_own) & $past(pa_pin_in[3:0], 3)))
    else $error("spi pin sync latency wrong");
  chk_int_sync_lat: assert property (
    run_reg == 2'h3 |->
      die_link_interrupt_in == ($past(die_link_enable) & $past(pc_pin_in[1], 3)))
    else $error("link interrupt sync wrong");
  chk_rsvd_reads_zero: assert property (
    run_reg != 2'h0 && $past(reg_rd) && $past(reg_addr) == pacg_pkg::OFS_RSVD_AFTER_A
      |-> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  chk_pa_upper_zero: assert property (
    run_reg != 2'h0 && $past(reg_rd) && $past(reg_addr) == pacg_pkg::OFS_PORT_A_DATA
      |-> reg_rdata[7:6] == 2'h0)
    else $error("port a upper bits set");
  chk_pc_upper_zero: assert property (
    run_reg != 2'h0 && $past(reg_rd) && $past(reg_addr) == pacg_pkg::OFS_PORT_C_DATA
      |-> reg_rdata[7:2] == 6'h00)
    else $error("port c upper bits set");
endmodule

bind pacg_top pacg_mon mon (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_rd, .reg_rdata,
  .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pc_pin_in, .pc_pin_out, .pc_pin_oe, .spi_own,
  .spi_drive, .spi_pin_sync, .die_link_enable, .die_link_clock_out, .die_link_interrupt_in);

/* File: test/testbench.sv */
// self-checking bench of the port a / port c pin block
`timescale 1ns/1ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  localparam logic [pacg_pkg::ADDR_W-1:0] a_dat = pacg_pkg::OFS_PORT_A_DATA;
  localparam logic [pacg_pkg::ADDR_W-1:0] a_dir = pacg_pkg::OFS_PORT_A_DIR;
  localparam logic [pacg_pkg::ADDR_W-1:0] c_dat = pacg_pkg::OFS_PORT_C_DATA;
  localparam logic [pacg_pkg::ADDR_W-1:0] c_dir = pacg_pkg::OFS_PORT_C_DIR;
  localparam logic [pacg_pkg::ADDR_W-1:0] rsv = pacg_pkg::OFS_RSVD_AFTER_A;
  logic ref_clk, rst_n, clk_en, reg_wr, reg_rd, link_req, rd_seen;
  logic [pacg_pkg::ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, c, ea, exp_v;
  logic [5:0] pa_pin_in, pa_pin_out, pa_pin_oe, m, p;
  logic [1:0] pc_pin_in, pc_pin_out, pc_pin_oe;
  logic [3:0] own_req, spi_own, spi_pin_sync;
  logic die_link_enable, die_link_clock_out, die_link_interrupt_in;
  pacg_pkg::pacg_spi_drive_t spi_drive;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int checks_done = 0;

  pacg_top dut (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pc_pin_in, .pc_pin_out, .pc_pin_oe,
    .spi_own, .spi_drive, .spi_pin_sync, .die_link_enable, .die_link_clock_out,
    .die_link_interrupt_in);
  pacg_periph_model peer (.ref_clk, .own_req, .link_req, .spi_own, .spi_drive,
    .die_link_enable, .die_link_clock_out);

  // ==========================================================================
  // register port tasks and read-result watcher
  task automatic wr(input logic [pacg_pkg::ADDR_W-1:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [pacg_pkg::ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // leaves the bus idle; checks that follow see the outputs before this
  // edge's updates land, so the next drive still happens right at the edge
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and scenarios
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    d = 8'($urandom(32'h1f917157));
    {rst_n, reg_wr, reg_rd, link_req, rd_seen} = 5'h00;
    clk_en = 1'b1;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    pa_pin_in = 6'h00;
    pc_pin_in = 2'h0;
    own_req = 4'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(a_dat, 8'h00);
    rd(rsv, 8'h00);
    rd(a_dir, 8'h00);
    rd(c_dat, 8'h00);
    rd(c_dir, 8'h00);
    idle(2);
    `CHK(pa_pin_oe, 6'h00)
    $display("reset test done");
    d = 8'($urandom);
    wr(a_dir, 8'hff);
    wr(a_dat, d);
    rd(a_dat, {2'b00, d[5:0]});
    rd(a_dir, 8'h3f);
    idle(2);
    `CHK(pa_pin_out, d[5:0])
    `CHK(pa_pin_oe, 6'h3f)
    $display("port a output test done");
    m = 6'($urandom);
    p = 6'($urandom);
    ea = {2'b00, (d[5:0] & m) | (p & ~m)};
    pa_pin_in <= p;
    wr(a_dir, {2'b00, m});
    idle(4);
    rd(a_dat, ea);
    idle(2);
    `CHK(pa_pin_oe, m)
    $display("port a input test done");
    // a write to the reserved place must not disturb the neighbour
    wr(rsv, 8'hff);
    rd(rsv, 8'h00);
    rd(a_dat, ea);
    rd(9'h1ff, 8'h00);
    idle(2);
    $display("reserved test done");
    c = 8'($urandom);
    pc_pin_in <= 2'b10;
    wr(c_dir, 8'hfe);
    wr(c_dat, c);
    idle(3);
    rd(c_dat, {6'h00, c[1], 1'b0});
    rd(c_dir, 8'h02);
    idle(2);
    `CHK(pc_pin_oe, 2'b10)
    `CHK(pc_pin_out[1], c[1])
    $display("port c test done");
    // a port c data write strobe while the clock enable is low must leave that register alone
    clk_en <= 1'b0;
    wr(c_dat, ~c);
    idle(2);
    clk_en <= 1'b1;
    rd(c_dat, {6'h00, c[1], 1'b0});
    idle(2);
    `CHK(pc_pin_out[1], c[1])
    $display("clock enable test done");
    own_req <= 4'hf;
    idle(4);
    rd(a_dir, {2'b00, m});
    idle(2);
    `CHK(pa_pin_oe[5:4], m[5:4])
    `CHK(pa_pin_oe[3:0], 4'he)
    own_req <= 4'h0;
    idle(3);
    `CHK(pa_pin_oe, m)
    $display("spi test done");
    link_req <= 1'b1;
    idle(6);
    `CHK(pc_pin_oe, 2'b01)
    `CHK(die_link_interrupt_in, 1'b1)
    rd(c_dir, 8'h02);
    link_req <= 1'b0;
    idle(3);
    `CHK(pc_pin_oe, 2'b10)
    $display("die link test done");
    give_verdict();
  end
endmodule
